/* File: pkg/ddscd_pkg.sv */
// Constants for the dual DAC serial command decoder.
// Assumes a single 250 MHz system clock and a slow host serial link.
package ddscd_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CNT_BITS = 5;
  localparam int POS_TARGET_HIGH = 15;
  localparam int POS_SPEED = 14;
  localparam int POS_POWER = 13;
  localparam int POS_TARGET_LOW = 12;
  localparam int POS_REF_HIGH = 1;
  localparam int POS_REF_LOW = 0;
  localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h0f;
  localparam logic [CNT_BITS-1:0] CNT_RESET = 5'h00;

  // ----------------------------------------------------------------
  // Target select codes and reference codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_B_AND_BUFFER = 2'h0;
  localparam logic [1:0] SEL_BUFFER = 2'h1;
  localparam logic [1:0] SEL_A_AND_MOVE = 2'h2;
  localparam logic [1:0] SEL_CONTROL = 2'h3;
  localparam logic [1:0] REF_INT_LOW = 2'h1;
  localparam logic [1:0] REF_INT_HIGH = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam logic [CODE_BITS-1:0] CODE_RESET = 12'h000;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] REF_RESET = 2'h0;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    DDSCD_IDLE,
    DDSCD_SHIFT,
    DDSCD_WAIT,
    DDSCD_DONE
  } ddscd_state_t;

endpackage

/* File: logic/ddscd_sync.sv */
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level from outside the clk domain.
`timescale 1ns/10ps
module ddscd_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

/* File: logic/ddscd_core.sv */
// Serial command port of a dual 12-bit DAC: shifts in 16-bit words and
// updates the channel latches, the buffer latch and the control register.
// Assumes the host drives serial clock, chip select and data as plain pins.
`timescale 1ns/10ps
// Operation
// - Control command with reference bits 1,0 selects internal 2.048 V reference.
// - Speed bit of every word sets fast (1) or slow (0) settling.
// - Select 10 loads the 12-bit value into the channel A latch.
// - Single-channel update happens on the rising serial clock after the last bit.
// - Control register holds its value across data writes.
// - Control command with reference bits 0,0 selects the external reference.
// - Select 00 writes the value into buffer and channel B latches.
// - Control command with reference bits 0,1 selects internal 1.024 V reference.
// - Select 01 writes only the buffer; both channel outputs stay unchanged.
// - Select 10 also copies buffer into channel B; both change together.
// - Bits arrive MSB first on falling edges; transfer after 16 bits or chip select rise.
// - Selects: 00 B+buffer, 01 buffer, 10 A plus buffer to B, 11 control.
// - Power bit of every word sets power-down (1) or normal operation (0).
// - Reset clears both channel latches, the buffer latch and control register.
module ddscd_core
  import ddscd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic [CODE_BITS-1:0] dac_a_code,
  output logic [CODE_BITS-1:0] dac_b_code,
  output logic [CODE_BITS-1:0] buffer_code,
  output logic settling_speed_bit,
  output logic power_down_bit,
  output logic reference_select_high,
  output logic reference_select_low,
  output logic reference_internal,
  output logic reference_high_range,
  output logic update_a,
  output logic update_b
);

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic sclk_d;
  logic cs_n_d;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;

  // The synchroniser resets to the idle pin levels; a reset value of zero would
  // show a chip-select fall and a clock fall to the edge detectors after reset.
  ddscd_sync #(
    .WIDTH(3),
    .RESET_VALUE(3'h6)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .din({sclk, cs_n, sdi}),
    .dout({sclk_s, cs_n_s, sdi_s})
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d <= 1'b1;
      cs_n_d <= 1'b1;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
    end
  end

  assign sclk_fall = sclk_d && !sclk_s;
  assign sclk_rise = !sclk_d && sclk_s;
  assign cs_fall = cs_n_d && !cs_n_s;
  assign cs_rise = !cs_n_d && cs_n_s;

  // ----------------------------------------------------------------
  // Word reception
  // ----------------------------------------------------------------
  ddscd_state_t state;
  logic [WORD_BITS-1:0] shift;
  logic [CNT_BITS-1:0] bit_cnt;
  logic commit;
  logic [1:0] sel;
  logic [CODE_BITS-1:0] data;

  // All three synchronised pins share the same delay, so data and clock
  // stay aligned; the host's hold time is covered by the slow link rate.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= DDSCD_IDLE;
      shift <= WORD_RESET;
      bit_cnt <= CNT_RESET;
    end else if (cs_n_s) begin
      state <= DDSCD_IDLE;
    end else if (cs_fall) begin
      state <= DDSCD_SHIFT;
      shift <= WORD_RESET;
      bit_cnt <= CNT_RESET;
    end else begin
      unique case (state)
        DDSCD_IDLE: begin
          state <= DDSCD_IDLE;
        end
        DDSCD_SHIFT: begin
          if (sclk_fall) begin
            shift <= {shift[WORD_BITS-2:0], sdi_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == LAST_BIT) begin
              state <= DDSCD_WAIT;
            end
          end
        end
        DDSCD_WAIT: begin
          if (sclk_rise) begin
            state <= DDSCD_DONE;
          end
        end
        DDSCD_DONE: begin
          state <= DDSCD_DONE;
        end
      endcase
    end
  end

  // A full word moves out on the rising clock after its last bit; a short
  // frame moves out when chip select rises, with the bits received so far.
  assign commit = (state == DDSCD_WAIT && (sclk_rise || cs_rise))
    || (state == DDSCD_SHIFT && cs_rise && bit_cnt != CNT_RESET);
  assign sel = {shift[POS_TARGET_HIGH], shift[POS_TARGET_LOW]};
  assign data = shift[CODE_BITS-1:0];

  // ----------------------------------------------------------------
  // Latches
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_a_code <= CODE_RESET;
      dac_b_code <= CODE_RESET;
      buffer_code <= CODE_RESET;
      update_a <= 1'b0;
      update_b <= 1'b0;
    end else begin
      update_a <= 1'b0;
      update_b <= 1'b0;
      if (commit) begin
        unique case (sel)
          SEL_B_AND_BUFFER: begin
            buffer_code <= data;
            dac_b_code <= data;
            update_b <= 1'b1;
          end
          SEL_BUFFER: begin
            buffer_code <= data;
          end
          SEL_A_AND_MOVE: begin
            dac_a_code <= data;
            dac_b_code <= buffer_code;
            update_a <= 1'b1;
            update_b <= 1'b1;
          end
          SEL_CONTROL: begin
            dac_a_code <= dac_a_code;
          end
        endcase
      end
    end
  end

  // The speed and power bits ride in every word, data writes included.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      settling_speed_bit <= 1'b0;
      power_down_bit <= 1'b0;
    end else if (commit) begin
      settling_speed_bit <= shift[POS_SPEED];
      power_down_bit <= shift[POS_POWER];
    end
  end

  // Reference bits change only on control commands and persist otherwise.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reference_select_high <= REF_RESET[1];
      reference_select_low <= REF_RESET[0];
      reference_internal <= 1'b0;
      reference_high_range <= 1'b0;
    end else if (commit && sel == SEL_CONTROL) begin
      reference_select_high <= shift[POS_REF_HIGH];
      reference_select_low <= shift[POS_REF_LOW];
      reference_internal <= shift[POS_REF_HIGH:POS_REF_LOW] == REF_INT_LOW
        || shift[POS_REF_HIGH:POS_REF_LOW] == REF_INT_HIGH;
      reference_high_range <= shift[POS_REF_HIGH:POS_REF_LOW] == REF_INT_HIGH;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chan_a_load_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_A_AND_MOVE |=> dac_a_code == $past(data) && update_a)
    else $error("Channel A latch did not take the word data.");

  both_move_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_A_AND_MOVE |=> dac_b_code == $past(buffer_code) && update_b)
    else $error("Channel B did not take the buffer with channel A.");

  chan_b_load_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_B_AND_BUFFER |=> dac_b_code == buffer_code
      && buffer_code == $past(data))
    else $error("Channel B and buffer not both written.");

  buffer_only_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_BUFFER |=> $stable(dac_a_code) && $stable(dac_b_code)
      && !update_a && !update_b)
    else $error("Buffer-only write disturbed a channel.");

  ref_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_CONTROL && data[1:0] == REF_INT_HIGH |=>
      reference_internal && reference_high_range)
    else $error("Internal high reference not selected.");

  ref_low_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_CONTROL && data[1:0] == REF_INT_LOW |=>
      reference_internal && !reference_high_range)
    else $error("Internal low reference not selected.");

  ref_ext_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_CONTROL && data[1:0] == 2'h0 |=> !reference_internal)
    else $error("External reference not selected.");

  ctrl_persist_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel != SEL_CONTROL |=> $stable(reference_internal)
      && $stable(reference_high_range))
    else $error("Control register changed on a data write.");

  speed_bit_a: assert property (@(posedge clk) disable iff (!resetn)
    commit |=> settling_speed_bit == $past(shift[POS_SPEED]))
    else $error("Speed bit not taken from the word.");

  power_bit_a: assert property (@(posedge clk) disable iff (!resetn)
    commit |=> power_down_bit == $past(shift[POS_POWER]))
    else $error("Power bit not taken from the word.");

  update_edge_a: assert property (@(posedge clk) disable iff (!resetn)
    state == DDSCD_WAIT && sclk_rise && !cs_n_s |-> commit ##1 state == DDSCD_DONE)
    else $error("Update missed the rising clock after the last bit.");

  sixteen_bits_a: assert property (@(posedge clk) disable iff (!resetn)
    state == DDSCD_SHIFT && !cs_n_s && sclk_fall && bit_cnt == LAST_BIT
      |=> state == DDSCD_WAIT)
    else $error("Word not complete after sixteen bits.");

  cs_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    cs_n_s && $past(cs_n_s) && $past(cs_n_s, 2) |-> $stable(dac_a_code)
      && $stable(dac_b_code) && $stable(buffer_code))
    else $error("Latch changed while chip select was high.");

  // The update pulses mark an output change and last one cycle only.
  update_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    update_a || update_b |=> !update_a && !update_b)
    else $error("Update pulse lasted more than one cycle.");

  chan_b_only_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_B_AND_BUFFER |=> update_b && !update_a && $stable(dac_a_code))
    else $error("Channel B write touched channel A.");

  ctrl_no_load_a: assert property (@(posedge clk) disable iff (!resetn)
    commit && sel == SEL_CONTROL |=> !update_a && !update_b && $stable(dac_a_code)
      && $stable(dac_b_code) && $stable(buffer_code))
    else $error("Control command changed a data latch.");

  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !commit |=> $stable(dac_a_code) && $stable(dac_b_code) && $stable(buffer_code)
      && !update_a && !update_b)
    else $error("Latch changed without a moved word.");

  shift_in_a: assert property (@(posedge clk) disable iff (!resetn)
    state == DDSCD_SHIFT && !cs_n_s && sclk_fall
      |=> shift == {$past(shift[WORD_BITS-2:0]), $past(sdi_s)}
      && bit_cnt == $past(bit_cnt) + 5'h01)
    else $error("Serial bit not shifted in MSB first.");

  short_frame_a: assert property (@(posedge clk) disable iff (!resetn)
    state == DDSCD_SHIFT && cs_rise && bit_cnt != CNT_RESET
      |=> power_down_bit == $past(shift[POS_POWER])
      && settling_speed_bit == $past(shift[POS_SPEED]))
    else $error("Short frame not moved on chip select rise.");

  done_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
    state == DDSCD_DONE |=> !update_a && !update_b && $stable(power_down_bit)
      && $stable(settling_speed_bit))
    else $error("Bits after a moved word were taken.");

  cs_high_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    cs_n_s && $past(cs_n_s) |=> state == DDSCD_IDLE && !update_a && !update_b)
    else $error("Frame logic ran while chip select was high.");

endmodule

/* File: tb/ddscd_host.sv */
// Host serial port model that drives chip select, serial clock and data.
// Assumes a free-running clk; every pin change lands on its falling edge.
`timescale 1ns/10ps
module ddscd_host (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  realtime last_rise;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    sdi = 1'b0;
    last_rise = 0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // The clock idles high; send runs it inside a frame, noise toggles it with chip select high.
  task automatic send(input logic [15:0] w, input int nbits);
    cs_n = 1'b0;
    wait_n(4);
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = w[i];
      wait_n(16);
      sclk = 1'b0;
      wait_n(16);
      sclk = 1'b1;
      last_rise = $realtime;
    end
    wait_n(8);
    cs_n = 1'b1;
    // A released data line shows the inverse, so a stale bit cannot look valid.
    sdi = ~sdi;
    wait_n(8);
  endtask
  task automatic noise();
    for (int i = 0; i < 32; i++) begin
      sdi = ~sdi;
      sclk = ~sclk;
      wait_n(8);
    end
  endtask
endmodule

/* File: tb/dual_dac_serial_command_decoder_bench.sv */
// Self-checking bench for the serial command decoder.
// Assumes the host model drives the serial pins; the bench drives clk and resetn.
`timescale 1ns/10ps
module dual_dac_serial_command_decoder_bench;
  import ddscd_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sclk, cs_n, sdi, speed, power, rsh, rsl, rint, rhi, upd_a, upd_b;
  logic [CODE_BITS-1:0] a_code, b_code, buf_code;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  realtime t_a, t_b;
  always #2 clk = ~clk;
  ddscd_host ddscd_host_i (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
  ddscd_core ddscd_core_i (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .sdi(sdi), .dac_a_code(a_code), .dac_b_code(b_code), .buffer_code(buf_code),
    .settling_speed_bit(speed), .power_down_bit(power), .reference_select_high(rsh),
    .reference_select_low(rsl), .reference_internal(rint),
    .reference_high_range(rhi), .update_a(upd_a), .update_b(upd_b));
  // ----------------------------------------------------------------
  // Comparison and reporting
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  // Control nibble order: speed, power, reference high, reference low.
  task automatic check_state(input logic [11:0] a, b, bf, input logic [3:0] ctl);
    check({4'h0, a_code}, {4'h0, a});
    check({4'h0, b_code}, {4'h0, b});
    check({4'h0, buf_code}, {4'h0, bf});
    check({12'h000, speed, power, rsh, rsl}, {12'h000, ctl});
    check({14'h0000, rint, rhi}, {14'h0000, ctl[1] ^ ctl[0], ctl[1] & ~ctl[0]});
  endtask
  always @(posedge clk) begin
    if (upd_a === 1'b1) t_a = $realtime;
    if (upd_b === 1'b1) t_b = $realtime;
    cycles++;
    if (cycles == 40000) begin
      bad_count++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_control();
    logic [15:0] words [4] = '{16'hd002, 16'h9001, 16'hd000, 16'hd003};
    logic [3:0] ctls [4] = '{4'b1010, 4'b0001, 4'b1000, 4'b1011};
    for (int i = 0; i < 4; i++) begin
      ddscd_host_i.send(words[i], 16);
      check_state(12'h000, 12'h000, 12'h000, ctls[i]);
    end
  endtask
  task automatic test_data();
    realtime lag;
    ddscd_host_i.send(16'h4abc, 16);
    check_state(12'h000, 12'habc, 12'habc, 4'b1011);
    lag = t_b - ddscd_host_i.last_rise;
    check({15'h0000, lag >= 8.0 && lag <= 24.0}, 16'h0001);
    ddscd_host_i.send(16'h1555, 16);
    check_state(12'h000, 12'habc, 12'h555, 4'b0011);
    check({15'h0000, t_b < ddscd_host_i.last_rise}, 16'h0001);
    ddscd_host_i.send(16'h8123, 16);
    check_state(12'h123, 12'h555, 12'h555, 4'b0011);
    check({15'h0000, t_a == t_b}, 16'h0001);
    lag = t_a - ddscd_host_i.last_rise;
    check({15'h0000, lag >= 8.0 && lag <= 24.0}, 16'h0001);
  endtask
  task automatic test_power_idle();
    ddscd_host_i.send(16'h2000, 16);
    check_state(12'h123, 12'h000, 12'h000, 4'b0111);
    ddscd_host_i.noise();
    ddscd_host_i.wait_n(16);
    check_state(12'h123, 12'h000, 12'h000, 4'b0111);
  endtask
  // A short frame is moved right-aligned when chip select rises.
  task automatic test_partial();
    ddscd_host_i.send(16'h005a, 8);
    check_state(12'h123, 12'h05a, 12'h05a, 4'b0011);
  endtask
  // A reset in mid-run clears every latch, then the port takes words again.
  task automatic test_reset_mid();
    resetn = 1'b0;
    ddscd_host_i.wait_n(4);
    check_state(12'h000, 12'h000, 12'h000, 4'h0);
    resetn = 1'b1;
    ddscd_host_i.wait_n(8);
    check_state(12'h000, 12'h000, 12'h000, 4'h0);
    ddscd_host_i.send(16'h4777, 16);
    check_state(12'h000, 12'h777, 12'h777, 4'h8);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    check_state(12'h000, 12'h000, 12'h000, 4'b0000);
    resetn = 1'b1;
    repeat (8) @(negedge clk);
    check_state(12'h000, 12'h000, 12'h000, 4'b0000);
    test_control();
    test_data();
    test_power_idle();
    test_partial();
    test_reset_mid();
    finish_test();
  end
endmodule
